// File: shared/input_fault_defs.vh
// constants for the input voltage fault configuration block
`ifndef INPUT_FAULT_DEFS_VH
`define INPUT_FAULT_DEFS_VH

// command codes
`define CMD_OV_ACTION 8'h56
`define CMD_UV_WARN 8'h58
`define CMD_START_DELAY 8'h60

// overvoltage action byte fields
`define ACT_HI 7
`define ACT_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DLY_HI 2
`define DLY_LO 0

// action codes
`define ACT_IGNORE 2'h0
`define ACT_DELAYED 2'h1
`define ACT_IMMEDIATE 2'h2
`define ACT_INVALID 2'h3

// retry codes
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// shutdown delay in switching clocks
`define SD_SHORT 3'h1
`define SD_MID 3'h3
`define SD_LONG 3'h7

// linear word fields
`define EXP_HI 15
`define EXP_LO 11
`define MAN_HI 10
`define MAN_LO 0

// reset exponents
`define UV_EXP_RESET 5'h1e
`define DLY_EXP_RESET 5'h1f

// threshold range in quarter volts: 2.5 V to 15.5 V
`define UV_FRAC 2
`define UV_MIN 10
`define UV_MAX 62

// start delay range in half milliseconds: 0 ms to 127.5 ms
`define DLY_FRAC 1
`define DLY_MIN 0
`define DLY_MAX 255

// timing
`define CLK_HZ 25000000
`define START_STEP_US 500
`define START_STEP_CYCLES ((`CLK_HZ / 1000000) * `START_STEP_US)

`endif

// File: design/linear_range_check.v
// converts a linear word to fixed point and checks it against a range
`timescale 1ns/1ps
`include "input_fault_defs.vh"

module linear_range_check #(
	parameter integer FRAC = 1,
	parameter integer MIN_VAL = 0,
	parameter integer MAX_VAL = 255,
	parameter integer EXACT = 1,
	parameter integer VW = 8
) (
	input wire [15:0] word,
	output reg in_range,
	output reg [VW-1:0] fixed
);

	reg signed [47:0] man_ext;
	reg signed [47:0] wide;
	reg signed [6:0] sh;
	reg [5:0] rs;
	reg [47:0] mask;
	reg lost;

	// value is mantissa times two to the exponent, both signed
	always @* begin
		man_ext = {{37{word[`MAN_HI]}}, word[`MAN_HI:`MAN_LO]};
		sh = {{2{word[`EXP_HI]}}, word[`EXP_HI:`EXP_LO]} + FRAC[6:0];
		rs = 6'h00;
		mask = 48'h0;
		lost = 1'b0;
		if (sh >= 0) begin
			wide = man_ext <<< sh[5:0];
		end else begin
			rs = -sh[5:0];
			mask = (48'h1 << rs) - 48'h1;
			lost = (man_ext & mask) != 48'h0;
			wide = man_ext >>> rs;
		end
		// floor with lost bits lies below the true value
		in_range = (wide >= MIN_VAL) && ((wide < MAX_VAL) || ((wide == MAX_VAL) && !lost))
			&& !((EXACT != 0) && lost);
		fixed = wide[VW-1:0];
	end

endmodule // linear_range_check

// File: design/tick_countdown.v
// loadable down counter stepped by a tick, one-cycle done pulse
`timescale 1ns/1ps

module tick_countdown #(
	parameter integer W = 8
) (
	input wire clk,
	input wire rst,
	input wire load,
	input wire [W-1:0] load_value,
	input wire tick,
	output reg done
);

	reg [W-1:0] count_q;
	reg busy_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= {W{1'b0}};
			busy_q <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				count_q <= load_value;
				busy_q <= (load_value != {W{1'b0}});
				done <= (load_value == {W{1'b0}});
			end else if (busy_q && tick) begin
				count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
				if (count_q == {{(W-1){1'b0}}, 1'b1}) begin
					busy_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule // tick_countdown

// File: design/input_voltage_fault_config.v
// input voltage fault configuration, response sequencer and start delay
//
// Operation
// - action byte at 56h, byte write and read
// - overvoltage sets status bits, notifies host
// - action 00b ignores fault, keeps regulating
// - action 01b delays, then shuts if persisting
// - action 10b shuts down at once, retries
// - action 11b unsupported, treated as invalid
// - retry 0 latches off after shutdown
// - retry 1-6 hiccup-spaced restarts, then latch
// - restarts under overvoltage still counted
// - retry 7 restarts forever until off/success
// - delay 0-1: one clock, hiccup one rise
// - delay 2-4: three clocks, hiccup code rises
// - delay 5-7: seven clocks, hiccup code rises
// - bad action write flagged invalid, notified
// - single undervoltage threshold at 58h
// - undervoltage warning sets status, notifies host
// - threshold linear, exponent resets, 2.5-15.5 V
// - out-of-range threshold write flagged invalid
// - start delay at 60h, start to rise
// - start delay linear word, not phased
// - delay exponent resets, 0-127.5 ms, checked
`timescale 1ns/1ps
`include "input_fault_defs.vh"

module input_voltage_fault_config #(
	parameter [7:0] OV_ACTION_RESET = 8'h80,
	parameter [10:0] UV_MAN_RESET = 11'h00c,
	parameter [10:0] DLY_MAN_RESET = 11'h000,
	parameter integer START_STEP_CYCLES = `START_STEP_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire cmd_write,
	input wire cmd_read,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	input wire clear_faults,
	input wire on_command,
	input wire input_overvoltage_detect,
	input wire input_undervoltage_detect,
	input wire pwm_tick,
	input wire rise_time_tick,
	input wire start_ok,
	output reg [15:0] rd_data,
	output reg rd_valid,
	output reg power_stage_enable,
	output reg latched_off,
	output reg status_none_above,
	output reg status_input,
	output reg input_high_fault_flag,
	output reg input_low_warning_flag,
	output reg invalid_data_flag,
	output reg host_notify,
	output reg [15:0] low_warning_threshold
);

	localparam [2:0] ST_OFF = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_SD_WAIT = 3'h3;
	localparam [2:0] ST_HICCUP = 3'h4;
	localparam [2:0] ST_LATCHED = 3'h5;

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	reg [7:0] ov_action_q;
	reg [15:0] start_delay_q;
	reg [7:0] start_steps_q;
	wire uv_ok;
	wire dly_ok;
	wire [7:0] dly_steps;
	wire [7:0] uv_fixed;
	wire action_ok;
	wire wr_action;
	wire wr_uv;
	wire wr_dly;
	wire write_bad;

	linear_range_check #(
		.FRAC(`UV_FRAC),
		.MIN_VAL(`UV_MIN),
		.MAX_VAL(`UV_MAX),
		.EXACT(0),
		.VW(8)
	) uv_check (
		.word(cmd_wdata),
		.in_range(uv_ok),
		.fixed(uv_fixed)
	);

	linear_range_check #(
		.FRAC(`DLY_FRAC),
		.MIN_VAL(`DLY_MIN),
		.MAX_VAL(`DLY_MAX),
		.EXACT(1),
		.VW(8)
	) dly_check (
		.word(cmd_wdata),
		.in_range(dly_ok),
		.fixed(dly_steps)
	);

	assign action_ok = cmd_wdata[`ACT_HI:`ACT_LO] != `ACT_INVALID;
	assign wr_action = cmd_write && (cmd_code == `CMD_OV_ACTION);
	assign wr_uv = cmd_write && (cmd_code == `CMD_UV_WARN);
	assign wr_dly = cmd_write && (cmd_code == `CMD_START_DELAY);
	assign write_bad = (wr_action && !action_ok) || (wr_uv && !uv_ok) || (wr_dly && !dly_ok);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ov_action_q <= OV_ACTION_RESET;
			low_warning_threshold <= {`UV_EXP_RESET, UV_MAN_RESET};
			start_delay_q <= {`DLY_EXP_RESET, DLY_MAN_RESET};
			start_steps_q <= DLY_MAN_RESET[7:0];
		end else begin
			if (wr_action && action_ok) begin
				ov_action_q <= cmd_wdata[7:0];
			end
			if (wr_uv && uv_ok) begin
				low_warning_threshold <= cmd_wdata;
			end
			if (wr_dly && dly_ok) begin
				start_delay_q <= cmd_wdata;
				start_steps_q <= dly_steps;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read back

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= cmd_read;
			if (cmd_read) begin
				case (cmd_code)
					`CMD_OV_ACTION: rd_data <= {8'h00, ov_action_q};
					`CMD_UV_WARN: rd_data <= low_warning_threshold;
					`CMD_START_DELAY: rd_data <= start_delay_q;
					default: rd_data <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags, set wins over clear

	reg ov_prev_q;
	reg uv_prev_q;
	wire ov_event;
	wire uv_event;

	assign ov_event = input_overvoltage_detect && !ov_prev_q;
	assign uv_event = input_undervoltage_detect && !uv_prev_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ov_prev_q <= 1'b0;
			uv_prev_q <= 1'b0;
			status_none_above <= 1'b0;
			status_input <= 1'b0;
			input_high_fault_flag <= 1'b0;
			input_low_warning_flag <= 1'b0;
			invalid_data_flag <= 1'b0;
			host_notify <= 1'b0;
		end else begin
			ov_prev_q <= input_overvoltage_detect;
			uv_prev_q <= input_undervoltage_detect;
			input_high_fault_flag <= ov_event || (input_high_fault_flag && !clear_faults);
			input_low_warning_flag <= uv_event || (input_low_warning_flag && !clear_faults);
			status_none_above <= ov_event || uv_event || (status_none_above && !clear_faults);
			status_input <= ov_event || uv_event || (status_input && !clear_faults);
			invalid_data_flag <= write_bad || (invalid_data_flag && !clear_faults);
			host_notify <= ov_event || uv_event || write_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// delay decode

	wire [1:0] action;
	wire [2:0] retry;
	wire [2:0] dly_code;
	reg [2:0] sd_cycles;
	reg [2:0] hiccup_rises;

	assign action = ov_action_q[`ACT_HI:`ACT_LO];
	assign retry = ov_action_q[`RETRY_HI:`RETRY_LO];
	assign dly_code = ov_action_q[`DLY_HI:`DLY_LO];

	always @* begin
		sd_cycles = `SD_SHORT;
		hiccup_rises = 3'h1;
		if (dly_code >= 3'h5) begin
			sd_cycles = `SD_LONG;
			hiccup_rises = dly_code;
		end else if (dly_code >= 3'h2) begin
			sd_cycles = `SD_MID;
			hiccup_rises = dly_code;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start delay prescaler

	reg [15:0] step_cnt_q;
	reg step_tick_q;
	reg [2:0] state_q;
	reg [2:0] state_d;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			step_cnt_q <= 16'h0000;
			step_tick_q <= 1'b0;
		end else if (state_q != ST_START) begin
			step_cnt_q <= 16'h0000;
			step_tick_q <= 1'b0;
		end else if (step_cnt_q == START_STEP_CYCLES[15:0] - 16'h0001) begin
			step_cnt_q <= 16'h0000;
			step_tick_q <= 1'b1;
		end else begin
			step_cnt_q <= step_cnt_q + 16'h0001;
			step_tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timers

	reg st_load;
	reg sd_load;
	reg hic_load;
	wire st_done;
	wire sd_done;
	wire hic_done;

	tick_countdown #(.W(8)) start_timer (
		.clk(clk),
		.rst(rst),
		.load(st_load),
		.load_value(start_steps_q),
		.tick(step_tick_q),
		.done(st_done)
	);

	tick_countdown #(.W(3)) shutdown_timer (
		.clk(clk),
		.rst(rst),
		.load(sd_load),
		.load_value(sd_cycles),
		.tick(pwm_tick),
		.done(sd_done)
	);

	tick_countdown #(.W(3)) hiccup_timer (
		.clk(clk),
		.rst(rst),
		.load(hic_load),
		.load_value(hiccup_rises),
		.tick(rise_time_tick),
		.done(hic_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// fault response sequencer

	reg [2:0] attempts_q;
	reg [2:0] attempts_d;
	reg enable_d;
	wire [2:0] attempts_inc;
	wire may_retry;
	wire may_retry_inc;

	assign attempts_inc = (attempts_q == 3'h7) ? attempts_q : attempts_q + 3'h1;
	assign may_retry = (retry == `RETRY_FOREVER) || (attempts_q < retry);
	assign may_retry_inc = (retry == `RETRY_FOREVER) || (attempts_inc < retry);

	always @* begin
		state_d = state_q;
		attempts_d = attempts_q;
		enable_d = power_stage_enable;
		st_load = 1'b0;
		sd_load = 1'b0;
		hic_load = 1'b0;
		if (!on_command) begin
			state_d = ST_OFF;
			enable_d = 1'b0;
			attempts_d = 3'h0;
		end else begin
			case (state_q)
				ST_OFF: begin
					state_d = ST_START;
					st_load = 1'b1;
				end
				ST_START: begin
					if (st_done) begin
						state_d = ST_RUN;
						enable_d = 1'b1;
					end
				end
				ST_RUN: begin
					if (start_ok) begin
						attempts_d = 3'h0;
					end
					if (input_overvoltage_detect) begin
						case (action)
							`ACT_DELAYED: begin
								state_d = ST_SD_WAIT;
								sd_load = 1'b1;
							end
							`ACT_IMMEDIATE: begin
								enable_d = 1'b0;
								state_d = may_retry ? ST_HICCUP : ST_LATCHED;
								hic_load = may_retry;
							end
							default: state_d = ST_RUN;
						endcase
					end
				end
				ST_SD_WAIT: begin
					if (sd_done) begin
						if (input_overvoltage_detect) begin
							enable_d = 1'b0;
							state_d = may_retry ? ST_HICCUP : ST_LATCHED;
							hic_load = may_retry;
						end else begin
							state_d = ST_RUN;
						end
					end
				end
				ST_HICCUP: begin
					if (hic_done) begin
						attempts_d = attempts_inc;
						if (input_overvoltage_detect) begin
							state_d = may_retry_inc ? ST_HICCUP : ST_LATCHED;
							hic_load = may_retry_inc;
						end else begin
							state_d = ST_RUN;
							enable_d = 1'b1;
						end
					end
				end
				ST_LATCHED: begin
					state_d = ST_LATCHED;
				end
				default: begin
					state_d = ST_OFF;
					enable_d = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_OFF;
			attempts_q <= 3'h0;
			power_stage_enable <= 1'b0;
			latched_off <= 1'b0;
		end else begin
			state_q <= state_d;
			attempts_q <= attempts_d;
			power_stage_enable <= enable_d;
			latched_off <= (state_d == ST_LATCHED);
		end
	end

endmodule // input_voltage_fault_config

// File: testbench/input_voltage_fault_config_asserts.sv
// checker for the input voltage fault block ports
`timescale 1ns/1ps
module input_voltage_fault_config_asserts #(
	parameter [7:0] OV_ACTION_RESET = 8'h80
) (
	input wire clk,
	input wire rst,
	input wire cmd_write,
	input wire cmd_read,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	input wire on_command,
	input wire input_overvoltage_detect,
	input wire input_undervoltage_detect,
	input wire rd_valid,
	input wire power_stage_enable,
	input wire latched_off,
	input wire status_none_above,
	input wire status_input,
	input wire input_high_fault_flag,
	input wire input_low_warning_flag,
	input wire invalid_data_flag,
	input wire host_notify
);
	reg [7:0] act_q;
	wire run_ov;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// shadow of the accepted action byte
	always @(posedge clk or posedge rst) begin
		if (rst)
			act_q <= OV_ACTION_RESET;
		else if (cmd_write && cmd_code == 8'h56 && cmd_wdata[7:6] != 2'b11)
			act_q <= cmd_wdata[7:0];
	end
	assign run_ov = power_stage_enable && on_command && input_overvoltage_detect;
	////////////////////////////////////////////////////////////////
	a_read_answer: assert property (cmd_read |=> rd_valid)
		else $error("read not answered");
	a_ov_status: assert property ($rose(input_overvoltage_detect) |=>
		input_high_fault_flag && status_none_above && status_input && host_notify)
		else $error("overvoltage status not raised");
	a_uv_status: assert property ($rose(input_undervoltage_detect) |=>
		input_low_warning_flag && status_none_above && status_input && host_notify)
		else $error("undervoltage status not raised");
	a_bad_action: assert property (cmd_write && cmd_code == 8'h56 &&
		cmd_wdata[7:6] == 2'b11 |=> invalid_data_flag && host_notify)
		else $error("unsupported action not flagged");
	a_latch_no_drive: assert property (latched_off |-> !power_stage_enable)
		else $error("switching while latched");
	a_off_clears: assert property (!on_command |=> !power_stage_enable && !latched_off)
		else $error("off command not obeyed");
	a_ignore_keeps: assert property (power_stage_enable && on_command &&
		act_q[7:6] == 2'b00 |=> power_stage_enable)
		else $error("ignore mode interrupted");
	a_immediate_shut: assert property (run_ov && act_q[7:6] == 2'b10 |=>
		!power_stage_enable)
		else $error("no immediate shutdown");
	a_delay_holds: assert property (run_ov && act_q[7:6] == 2'b01 &&
		$rose(input_overvoltage_detect) |=> power_stage_enable)
		else $error("delayed mode shut at once");
	c_shutdown: cover property ($fell(power_stage_enable));
	c_latched: cover property ($rose(latched_off));
	c_invalid: cover property ($rose(invalid_data_flag));
endmodule // input_voltage_fault_config_asserts

bind input_voltage_fault_config input_voltage_fault_config_asserts #(
	.OV_ACTION_RESET(OV_ACTION_RESET)
) i_input_voltage_fault_config_asserts (.clk, .rst, .cmd_write, .cmd_read, .cmd_code,
	.cmd_wdata, .on_command, .input_overvoltage_detect, .input_undervoltage_detect, .rd_valid,
	.power_stage_enable, .latched_off, .status_none_above, .status_input, .input_high_fault_flag,
	.input_low_warning_flag, .invalid_data_flag, .host_notify);

// File: testbench/host_model.sv
// host controller model issuing register commands
`timescale 1ns/1ps
module host_model (
	input wire clk,
	input wire rd_valid,
	input wire [15:0] rd_data,
	output reg cmd_write,
	output reg cmd_read,
	output reg [7:0] cmd_code,
	output reg [15:0] cmd_wdata
);
	integer n;
	initial begin
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// idle bus shows the inverse of the last command
	task idle;
		begin
			cmd_write = 1'b0;
			cmd_read = 1'b0;
			cmd_code = ~cmd_code;
			cmd_wdata = ~cmd_wdata;
		end
	endtask
	// whole word, one command per edge
	task wr(input [7:0] code, input [15:0] data);
		begin
			// an edge passes between commands so no strobe toggles in one step
			@(posedge clk);
			#1;
			cmd_code = code;
			cmd_wdata = data;
			cmd_write = 1'b1;
			@(posedge clk);
			#1;
			idle;
		end
	endtask
	task rd(input [7:0] code, output [15:0] data);
		begin
			@(posedge clk);
			#1;
			cmd_code = code;
			cmd_read = 1'b1;
			@(posedge clk);
			#1;
			idle;
			n = 0;
			while (rd_valid !== 1'b1 && n < 8) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			data = rd_data;
		end
	endtask
endmodule // host_model

// File: testbench/input_voltage_fault_config_tb_top.sv
// testbench for the input voltage fault block
`timescale 1ns/1ps
module input_voltage_fault_config_tb_top;
	reg clk;
	reg rst;
	reg clear_faults;
	reg on_command;
	reg input_overvoltage_detect;
	reg input_undervoltage_detect;
	reg pwm_tick = 1'b0;
	reg rise_time_tick = 1'b0;
	reg start_ok;
	wire cmd_write;
	wire cmd_read;
	wire [7:0] cmd_code;
	wire [15:0] cmd_wdata;
	wire [15:0] rd_data;
	wire rd_valid;
	wire power_stage_enable;
	wire latched_off;
	wire status_none_above;
	wire status_input;
	wire input_high_fault_flag;
	wire input_low_warning_flag;
	wire invalid_data_flag;
	wire host_notify;
	wire [15:0] low_warning_threshold;
	integer bad_count;
	integer checked;
	integer cyc = 0;
	integer i;
	integer n;
	integer cnt;
	reg nt;
	reg [15:0] rdv;

	input_voltage_fault_config #(.START_STEP_CYCLES(4)) i_input_voltage_fault_config (.clk, .rst,
		.cmd_write, .cmd_read, .cmd_code, .cmd_wdata, .clear_faults, .on_command,
		.input_overvoltage_detect, .input_undervoltage_detect, .pwm_tick, .rise_time_tick,
		.start_ok, .rd_data, .rd_valid, .power_stage_enable, .latched_off, .status_none_above,
		.status_input, .input_high_fault_flag, .input_low_warning_flag, .invalid_data_flag,
		.host_notify, .low_warning_threshold);
	host_model i_host_model (.clk, .rd_valid, .rd_data, .cmd_write, .cmd_read, .cmd_code,
		.cmd_wdata);
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// switching and rise time ticks
	always @(posedge clk) begin
		#1;
		cyc = cyc + 1;
		pwm_tick = (cyc % 5 == 0);
		rise_time_tick = (cyc % 3 == 0);
	end
	////////////////////////////////////////////////////////////////
	task step(input integer k);
		begin
			repeat (k) @(posedge clk);
			#1;
		end
	endtask
	task chk(input [8*6-1:0] name, input [15:0] seen, input [15:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task print_verdict;
		begin
			if (bad_count == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task wtry(input [7:0] code, input [15:0] data, input bad, input [15:0] back);
		begin
			clear_faults = 1'b1;
			step(1);
			clear_faults = 1'b0;
			i_host_model.wr(code, data);
			nt = host_notify;
			step(1);
			nt = nt | host_notify;
			chk("notify", nt, bad);
			chk("inval", invalid_data_flag, bad);
			i_host_model.rd(code, rdv);
			chk("back", rdv, back);
		end
	endtask
	task wait_on;
		begin
			n = 0;
			while (power_stage_enable !== 1'b1 && n < 100) begin
				step(1);
				n = n + 1;
			end
		end
	endtask
	task restart(input [7:0] act);
		begin
			i_host_model.wr(8'h56, {8'h00, act});
			on_command = 1'b0;
			clear_faults = 1'b1;
			step(2);
			clear_faults = 1'b0;
			on_command = 1'b1;
			wait_on;
		end
	endtask
	// counts ticks seen by the design until shutdown or latch
	task watch(input sel);
		begin
			cnt = 0;
			n = 0;
			while ((sel ? latched_off !== 1'b1 : power_stage_enable !== 1'b0) && n < 400) begin
				@(posedge clk);
				// the shutdown timer ignores a tick on its own load edge
				cnt = cnt + (sel ? rise_time_tick : (n > 0 ? pwm_tick : 1'b0));
				#1;
				n = n + 1;
			end
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		bad_count = bad_count + 1;
		print_verdict;
	end
	initial begin
		rst = 1'b1;
		clear_faults = 1'b0;
		on_command = 1'b0;
		input_overvoltage_detect = 1'b0;
		input_undervoltage_detect = 1'b0;
		start_ok = 1'b0;
		bad_count = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		i_host_model.rd(8'h56, rdv);
		chk("act", rdv, 16'h0080);
		i_host_model.rd(8'h58, rdv);
		chk("uvrst", rdv, 16'hf00c);
		i_host_model.rd(8'h60, rdv);
		chk("dlyrst", rdv, 16'hf800);
		wtry(8'h56, 16'h0088, 1'b0, 16'h0088);
		wtry(8'h56, 16'h00c5, 1'b1, 16'h0088);
		wtry(8'h58, 16'hf00a, 1'b0, 16'hf00a);
		wtry(8'h58, 16'hf81f, 1'b0, 16'hf81f);
		wtry(8'h58, 16'hf008, 1'b1, 16'hf81f);
		wtry(8'h58, 16'hf820, 1'b1, 16'hf81f);
		chk("uvthr", low_warning_threshold, 16'hf81f);
		wtry(8'h60, 16'hf8ff, 1'b0, 16'hf8ff);
		wtry(8'h60, 16'hf900, 1'b1, 16'hf8ff);
		wtry(8'h60, 16'hf001, 1'b1, 16'hf8ff);
		wtry(8'h60, 16'h07ff, 1'b1, 16'hf8ff);
		wtry(8'h60, 16'h0002, 1'b0, 16'h0002);
		wtry(8'h12, 16'h1234, 1'b0, 16'h0000);
		on_command = 1'b1;
		wait_on;
		chk("tondly", {15'h0000, n >= 16 && n <= 20}, 16'h0001);
		for (i = 0; i < 3; i = i + 1) begin
			restart(i == 0 ? 8'h41 : i == 1 ? 8'h43 : 8'h46);
			input_overvoltage_detect = 1'b1;
			watch(1'b0);
			chk("sdly", cnt[15:0], i == 0 ? 16'h0001 : i == 1 ? 16'h0003 : 16'h0007);
			watch(1'b1);
			chk("latch", latched_off, 1'b1);
			input_overvoltage_detect = 1'b0;
		end
		restart(8'h92);
		input_overvoltage_detect = 1'b1;
		watch(1'b0);
		chk("ovflag", {input_high_fault_flag, status_none_above, status_input}, 16'h0007);
		watch(1'b1);
		chk("hiccup", cnt[15:0], 16'h0004);
		restart(8'h00);
		step(40);
		chk("ignore", power_stage_enable, 1'b1);
		restart(8'hb8);
		watch(1'b1);
		chk("forevr", latched_off, 1'b0);
		input_overvoltage_detect = 1'b0;
		wait_on;
		chk("resume", power_stage_enable, 1'b1);
		start_ok = 1'b1;
		step(1);
		start_ok = 1'b0;
		on_command = 1'b0;
		step(2);
		chk("off", power_stage_enable, 1'b0);
		clear_faults = 1'b1;
		step(1);
		clear_faults = 1'b0;
		input_undervoltage_detect = 1'b1;
		step(2);
		chk("uvflag", input_low_warning_flag, 1'b1);
		input_undervoltage_detect = 1'b0;
		step(2);
		print_verdict;
	end
endmodule // input_voltage_fault_config_tb_top
